// ===== shared/sdsc_pkg.sv
// sdsc_pkg: register map, field layout and timing constants of the sd
// system control block. assumes a 32-bit classic wishbone register bus.
package sdsc_pkg;
    // register byte offsets
    localparam logic [7:0] SYSCTL_OFF = 8'h00;
    localparam logic [7:0] STATUS_OFF = 8'h04;
    localparam logic [7:0] IRQST_OFF  = 8'h08;
    localparam logic [7:0] IRQEN_OFF  = 8'h0c;
    localparam logic [7:0] EVENT_OFF  = 8'h10;

    // control register field positions
    localparam int ICE_BIT   = 0;
    localparam int ICS_BIT   = 1;
    localparam int CEN_BIT   = 2;
    localparam int CARD_CLOCK_DIVIDER_LSB  = 6;
    localparam int CARD_CLOCK_DIVIDER_W    = 10;
    localparam int TSEL_LSB  = 16;
    localparam int TSEL_W    = 4;
    localparam int SRA_BIT   = 24;
    localparam int SRC_BIT   = 25;
    localparam int SRD_BIT   = 26;
    localparam logic [31:0] SYSCTL_RESET = 32'h0000_0000;

    // status register fields (data-line and command-line flags)
    localparam int ST_BRE  = 0;
    localparam int ST_BWE  = 1;
    localparam int ST_RTA  = 2;
    localparam int ST_WTA  = 3;
    localparam int ST_DLA  = 4;
    localparam int ST_DATA_INHIBIT = 5;
    localparam int ST_COMMAND_INHIBIT = 6;
    localparam int ST_STOP_AT_GAP_REQUEST = 7;
    localparam int ST_CR   = 8;
    localparam int ST_AGT  = 9;

    // interrupt bits
    localparam int IRQ_W    = 8;
    localparam int IQ_DTO   = 0;
    localparam int IQ_BUSY  = 1;
    localparam int IQ_CRCT  = 2;
    localparam int IQ_CC    = 3;
    localparam int IQ_TC    = 4;
    localparam int IQ_BRR   = 5;
    localparam int IQ_BWR   = 6;
    localparam int IQ_BGE   = 7;

    // timing
    localparam int          TO_BASE_EXP   = 13;
    localparam logic [3:0]  TSEL_RESVD    = 4'hf;
    localparam int          CLK_MHZ       = 100;
    localparam int          SETTLE_NS     = 100;
    localparam int          SETTLE_CYC    = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int          RESET_CYC     = 4;

    typedef enum logic [1:0] {
        SDSC_RST_IDLE = 2'b00,
        SDSC_RST_RUN  = 2'b01,
        SDSC_RST_DONE = 2'b10
    } sdsc_rst_e;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } sdsc_wb_rsp_s;
endpackage

// ===== core/sdsc_clkdiv.sv
// sdsc_clkdiv: card clock divider and internal clock stable tracking.
// assumes ref clock enable on clk_i domain; output is an enable-based clock.
`timescale 1ns/1ps
`default_nettype none
module sdsc_clkdiv #(
    parameter int DIV_W = 10
) (
    input  wire logic             clk_i,    // system clock
    input  wire logic             rst_i,    // sync reset, high
    input  wire logic             ce_i,     // clock enable
    input  wire logic             ice_i,    // internal clock enable
    input  wire logic             cen_i,    // card clock enable
    input  wire logic             gate_i,   // auto-idle gating request
    input  wire logic [DIV_W-1:0] div_i,    // divider value
    output logic                  ics_o,    // internal clock stable
    output logic                  card_clk_o // divided card clock
);
    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic [DIV_W-1:0] div_seen;
        logic [7:0]       settle;
        logic             stable;
        logic             ph;
        logic             cclk;
    } sdsc_div_s;
    sdsc_div_s s_reg, s_next;

    initial begin
        if (DIV_W < 2 || sdsc_pkg::SETTLE_CYC > 255) $error("sdsc_clkdiv: bad parameters");
    end

    // divider, settle counter; stable drops on any divider change
    always_comb begin
        s_next = s_reg;
        if (!ice_i) begin
            s_next.stable = 1'b0; // [R16]
            s_next.settle = '0;
            s_next.cnt    = '0;
            s_next.ph     = 1'b0;
        end else begin
            if (div_i != s_reg.div_seen) begin
                s_next.div_seen = div_i;
                s_next.stable   = 1'b0; // [R15]
                s_next.settle   = '0;
            end else if (!s_reg.stable) begin
                if (s_reg.settle == 8'(sdsc_pkg::SETTLE_CYC - 1)) s_next.stable = 1'b1; // [R15]
                else s_next.settle = s_reg.settle + 8'h01;
            end
            // values 0 and 1 bypass: phase follows each clk enable
            if (div_i <= DIV_W'(1)) begin // [R12]
                s_next.ph  = ~s_reg.ph;
                s_next.cnt = '0;
            end else if (s_reg.cnt >= div_i - DIV_W'(1)) begin
                s_next.cnt = '0;
                s_next.ph  = 1'b1;
            end else begin
                s_next.cnt = s_reg.cnt + DIV_W'(1);
                if (s_reg.cnt == (div_i >> 1) - DIV_W'(1)) s_next.ph = 1'b0;
            end
        end
        // no clock reaches the card unless enabled and not idle-gated
        s_next.cclk = s_next.ph & cen_i & ice_i & ~gate_i; // [R13]
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) s_reg <= '0;
        else if (ce_i) s_reg <= s_next;
    end

    assign ics_o      = s_reg.stable;
    assign card_clk_o = s_reg.cclk;

    property p_cen_off;
        @(posedge clk_i) disable iff (rst_i) (ce_i && !cen_i) |=> !s_reg.cclk;
    endproperty
    a_cen_off: assert property (p_cen_off) else $error("card clock ran while disabled"); // [R13]

    property p_div_unstable;
        @(posedge clk_i) disable iff (rst_i)
            (ce_i && ice_i && div_i != s_reg.div_seen) |=> !s_reg.stable;
    endproperty
    a_div_unstable: assert property (p_div_unstable) else $error("stable after divider change"); // [R15]

    property p_ice_off;
        @(posedge clk_i) disable iff (rst_i) (ce_i && !ice_i) |=> !s_reg.stable;
    endproperty
    a_ice_off: assert property (p_ice_off) else $error("stable with clock off"); // [R16]
endmodule // sdsc_clkdiv
`default_nettype wire

// ===== core/sdsc_timeout.sv
// sdsc_timeout: power-of-two data, busy and crc token time-out counter.
// assumes a one-cycle time-out clock tick input from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module sdsc_timeout #(
    parameter int CNT_W = 28
) (
    input  wire logic       clk_i,   // system clock
    input  wire logic       rst_i,   // sync reset, high
    input  wire logic       ce_i,    // clock enable
    input  wire logic       clr_i,   // abort, from data-line reset
    input  wire logic       tick_i,  // time-out clock base tick
    input  wire logic       arm_i,   // waiting on card (level)
    input  wire logic [3:0] sel_i,   // timeout_select code
    output logic            exp_o    // one-cycle expiry pulse
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             fired;
        logic             exp;
    } sdsc_to_s;
    sdsc_to_s s_reg, s_next;

    initial begin
        if (CNT_W < sdsc_pkg::TO_BASE_EXP + 15) $error("sdsc_timeout: counter too narrow");
    end

    // limit = 2^(13+sel); code 15 reserved, never fires
    function automatic logic [CNT_W-1:0] limit_f(input logic [3:0] sel);
        limit_f = CNT_W'(1) << (sdsc_pkg::TO_BASE_EXP + int'(sel)); // [R7]
    endfunction

    always_comb begin
        s_next     = s_reg;
        s_next.exp = 1'b0;
        if (clr_i || !arm_i) begin
            s_next.cnt   = '0;
            s_next.fired = 1'b0;
        end else if (tick_i && !s_reg.fired && sel_i != sdsc_pkg::TSEL_RESVD) begin
            if (s_reg.cnt == limit_f(sel_i) - CNT_W'(1)) begin
                s_next.exp   = 1'b1; // [R8]
                s_next.fired = 1'b1;
            end else s_next.cnt = s_reg.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) s_reg <= '0;
        else if (ce_i) s_reg <= s_next;
    end

    assign exp_o = s_reg.exp;

    property p_no_fire_unarmed;
        @(posedge clk_i) disable iff (rst_i) (ce_i && !arm_i) |=> !s_reg.exp;
    endproperty
    a_no_fire_unarmed: assert property (p_no_fire_unarmed) else $error("timeout while idle"); // [R8]

    property p_resvd;
        @(posedge clk_i) disable iff (rst_i)
            (sel_i == 4'hf && $stable(sel_i)) |=> !s_reg.exp;
    endproperty
    a_resvd: assert property (p_resvd) else $error("reserved code fired"); // [R7]
endmodule // sdsc_timeout
`default_nettype wire

// ===== core/sdsc_sysctl.sv
// sdsc_sysctl: sd host system control: soft resets, time-outs, card clock.
// assumes a classic wishbone master and data/cmd engines driving event pins.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [R1] data reset clears data fsms, self-clears
// [R2] data reset clears data flags and requests
// [R3] data reset flushes buffer handling state
// [R4] command reset clears cmd fsm, flags, self-clears
// [R5] command reset drops pending command status
// [R6] global reset resets all but detect/capabilities
// [R7] time-out is base times 2^(13+code)
// [R8] no card answer raises data time-out
// [R9] same period bounds busy duration
// [R10] missing crc token after write times out
// [R11] software picks code from card timing
// [R12] divider sets card clock, 0/1 bypass
// [R13] card clock enable gates card clock
// [R14] software enables card clock after stable
// [R15] stable flag set only after settling
// [R16] internal clock enable stops internal clock
// [R17] reset bits read one while busy
module sdsc_sysctl #(
    parameter int DIV_W = 10,
    parameter int CNT_W = 28
) (
    input  wire logic        clk_i,        // system clock
    input  wire logic        rst_i,        // sync reset, high
    input  wire logic        ce_i,         // clock enable
    input  wire logic        wb_cyc_i,     // wishbone cycle
    input  wire logic        wb_stb_i,     // wishbone strobe
    input  wire logic        wb_we_i,      // write enable
    input  wire logic [7:0]  wb_adr_i,     // byte address
    input  wire logic [3:0]  wb_sel_i,     // byte lanes
    input  wire logic [31:0] wb_dat_i,     // write data
    output logic             wb_ack_o,     // acknowledge
    output logic [31:0]      wb_dat_o,     // read data
    input  wire logic        tick_i,       // time-out base tick
    input  wire logic        gate_i,       // auto-idle gating request
    input  wire logic        data_wait_i,  // waiting for read data
    input  wire logic        busy_wait_i,  // card holds busy
    input  wire logic        crc_wait_i,   // waiting crc token
    input  wire logic [7:0]  ev_i,         // engine event pulses
    input  wire logic [6:0]  flag_set_i,   // engine sets status flags
    input  wire logic [6:0]  flag_clr_i,   // engine clears status flags
    output logic             irq_o,        // level interrupt
    output logic             card_clk_o,   // card clock
    output logic             data_rst_o,   // data-line fsm reset
    output logic             cmd_rst_o,    // command-line fsm reset
    output logic             all_rst_o     // whole-controller reset
);
    typedef struct packed {
        logic                           ack;
        logic [31:0]                    dat;
        logic                           internal_clock_enable;
        logic                           card_clock_enable;
        logic [DIV_W-1:0]               div;
        logic [3:0]                     tsel;
        sdsc_pkg::sdsc_rst_e            srd_st;
        sdsc_pkg::sdsc_rst_e            src_st;
        sdsc_pkg::sdsc_rst_e            sra_st;
        logic [2:0]                     rcnt;
        logic [sdsc_pkg::ST_AGT-1:0]    flags;
        logic [7:0]                     irq_st;
        logic [7:0]                     irq_en;
        logic                           irq;
        logic                           drst;
        logic                           crst;
        logic                           arst;
        logic                           drst_pin;
        logic                           crst_pin;
    } sdsc_top_s;
    sdsc_top_s s_reg, s_next;

    logic       internal_clock_stable;
    logic       cclk;
    logic       to_data, to_busy, to_crc;
    logic [7:0] ev_all;

    initial begin
        if (DIV_W != sdsc_pkg::CARD_CLOCK_DIVIDER_W) $error("sdsc_sysctl: divider width");
    end

    // write a masked byte-lane merge
    function automatic logic [31:0] merge_f(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            merge_f[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    // reset sequencer: request, hold for RESET_CYC, return to idle
    function automatic sdsc_pkg::sdsc_rst_e rst_step_f(input sdsc_pkg::sdsc_rst_e st,
                                                       input logic go, input logic done);
        rst_step_f = st;
        case (st)
            sdsc_pkg::SDSC_RST_IDLE: if (go) rst_step_f = sdsc_pkg::SDSC_RST_RUN;
            sdsc_pkg::SDSC_RST_RUN:  if (done) rst_step_f = sdsc_pkg::SDSC_RST_DONE;
            default:                 rst_step_f = sdsc_pkg::SDSC_RST_IDLE;
        endcase
    endfunction

    function automatic logic [31:0] sysctl_f(input sdsc_top_s s, input logic stable);
        sysctl_f = '0;
        sysctl_f[sdsc_pkg::ICE_BIT] = s.internal_clock_enable;
        sysctl_f[sdsc_pkg::ICS_BIT] = stable;
        sysctl_f[sdsc_pkg::CEN_BIT] = s.card_clock_enable;
        sysctl_f[sdsc_pkg::CARD_CLOCK_DIVIDER_LSB +: sdsc_pkg::CARD_CLOCK_DIVIDER_W] = s.div;
        sysctl_f[sdsc_pkg::TSEL_LSB +: sdsc_pkg::TSEL_W] = s.tsel;
        sysctl_f[sdsc_pkg::SRA_BIT] = (s.sra_st != sdsc_pkg::SDSC_RST_IDLE); // [R17]
        sysctl_f[sdsc_pkg::SRC_BIT] = (s.src_st != sdsc_pkg::SDSC_RST_IDLE); // [R17]
        sysctl_f[sdsc_pkg::SRD_BIT] = (s.srd_st != sdsc_pkg::SDSC_RST_IDLE); // [R17]
    endfunction

    sdsc_clkdiv #(.DIV_W(DIV_W)) u_div (
        .clk_i      (clk_i),
        .rst_i      (rst_i | s_reg.arst),
        .ce_i       (ce_i),
        .ice_i      (s_reg.internal_clock_enable),
        .cen_i      (s_reg.card_clock_enable),
        .gate_i     (gate_i),
        .div_i      (s_reg.div),
        .ics_o      (internal_clock_stable),
        .card_clk_o (cclk)
    );

    // one counter per wait kind; all share the selected period
    sdsc_timeout #(.CNT_W(CNT_W)) u_to_data (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .clr_i  (s_reg.drst | s_reg.arst),
        .tick_i (tick_i),
        .arm_i  (data_wait_i),
        .sel_i  (s_reg.tsel),
        .exp_o  (to_data)
    );
    sdsc_timeout #(.CNT_W(CNT_W)) u_to_busy (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .clr_i  (s_reg.drst | s_reg.arst),
        .tick_i (tick_i),
        .arm_i  (busy_wait_i), // [R9]
        .sel_i  (s_reg.tsel),
        .exp_o  (to_busy)
    );
    sdsc_timeout #(.CNT_W(CNT_W)) u_to_crc (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .clr_i  (s_reg.drst | s_reg.arst),
        .tick_i (tick_i),
        .arm_i  (crc_wait_i), // [R10]
        .sel_i  (s_reg.tsel),
        .exp_o  (to_crc)
    );

    // events: engine pulses plus the three time-outs
    always_comb begin
        ev_all = ev_i;
        ev_all[sdsc_pkg::IQ_DTO]  = ev_i[sdsc_pkg::IQ_DTO] | to_data; // [R8]
        ev_all[sdsc_pkg::IQ_BUSY] = ev_i[sdsc_pkg::IQ_BUSY] | to_busy; // [R9]
        ev_all[sdsc_pkg::IQ_CRCT] = ev_i[sdsc_pkg::IQ_CRCT] | to_crc; // [R10]
    end

    // bus, reset sequencing, flags and interrupt
    always_comb begin
        logic        acc;
        logic        wr;
        logic [31:0] wv;
        logic [31:0] cur;
        logic        go_d, go_c, go_a;
        logic        done;
        logic [7:0]  w1c;
        acc  = wb_cyc_i & wb_stb_i & ~s_reg.ack;
        wr   = acc & wb_we_i;
        cur  = sysctl_f(s_reg, internal_clock_stable);
        wv   = merge_f(cur, wb_dat_i, wb_sel_i);
        go_d = 1'b0;
        go_c = 1'b0;
        go_a = 1'b0;
        w1c  = '0;
        done = (s_reg.rcnt == 3'(sdsc_pkg::RESET_CYC - 1));
        s_next     = s_reg;
        s_next.ack = acc;
        s_next.dat = '0;
        if (wr && wb_adr_i == sdsc_pkg::SYSCTL_OFF) begin
            s_next.internal_clock_enable  = wv[sdsc_pkg::ICE_BIT];
            s_next.card_clock_enable  = wv[sdsc_pkg::CEN_BIT];
            s_next.div  = wv[sdsc_pkg::CARD_CLOCK_DIVIDER_LSB +: sdsc_pkg::CARD_CLOCK_DIVIDER_W];
            s_next.tsel = wv[sdsc_pkg::TSEL_LSB +: sdsc_pkg::TSEL_W];
            go_d = wv[sdsc_pkg::SRD_BIT] & wb_sel_i[3];
            go_c = wv[sdsc_pkg::SRC_BIT] & wb_sel_i[3];
            go_a = wv[sdsc_pkg::SRA_BIT] & wb_sel_i[3];
        end else if (wr && wb_adr_i == sdsc_pkg::IRQST_OFF) begin
            w1c = wb_dat_i[7:0] & {8{wb_sel_i[0]}};
        end else if (wr && wb_adr_i == sdsc_pkg::IRQEN_OFF) begin
            if (wb_sel_i[0]) s_next.irq_en = wb_dat_i[7:0];
        end
        if (acc && !wb_we_i) begin
            if (wb_adr_i == sdsc_pkg::SYSCTL_OFF) s_next.dat = cur;
            else if (wb_adr_i == sdsc_pkg::STATUS_OFF) s_next.dat = 32'(s_reg.flags);
            else if (wb_adr_i == sdsc_pkg::IRQST_OFF) s_next.dat = 32'(s_reg.irq_st);
            else if (wb_adr_i == sdsc_pkg::IRQEN_OFF) s_next.dat = 32'(s_reg.irq_en);
            else s_next.dat = '0;
        end
        // shared hold counter for the running resets
        if (s_reg.srd_st == sdsc_pkg::SDSC_RST_RUN || s_reg.src_st == sdsc_pkg::SDSC_RST_RUN
            || s_reg.sra_st == sdsc_pkg::SDSC_RST_RUN) begin
            s_next.rcnt = done ? 3'h0 : s_reg.rcnt + 3'h1;
        end else s_next.rcnt = 3'h0;
        s_next.srd_st = rst_step_f(s_reg.srd_st, go_d, done); // [R1]
        s_next.src_st = rst_step_f(s_reg.src_st, go_c, done); // [R4]
        s_next.sra_st = rst_step_f(s_reg.sra_st, go_a, done); // [R6]
        s_next.drst = (s_next.srd_st == sdsc_pkg::SDSC_RST_RUN); // [R1]
        s_next.crst = (s_next.src_st == sdsc_pkg::SDSC_RST_RUN); // [R4]
        s_next.arst = (s_next.sra_st == sdsc_pkg::SDSC_RST_RUN); // [R6]
        // pins also carry the global reset, registered so they never glitch
        s_next.drst_pin = s_next.drst | s_next.arst; // [R3]
        s_next.crst_pin = s_next.crst | s_next.arst;
        // flags: engine set wins over engine clear
        s_next.flags[6:0] = (s_reg.flags[6:0] & ~flag_clr_i) | flag_set_i;
        s_next.flags[sdsc_pkg::ST_STOP_AT_GAP_REQUEST] = s_reg.flags[sdsc_pkg::ST_STOP_AT_GAP_REQUEST]
                                          | ev_i[sdsc_pkg::IQ_BGE];
        s_next.flags[sdsc_pkg::ST_CR] = 1'b0;
        // sticky status: set wins over write-one clear
        s_next.irq_st = (s_reg.irq_st & ~w1c) | ev_all;
        if (s_reg.drst) begin
            s_next.flags[sdsc_pkg::ST_DATA_INHIBIT:0] = '0; // [R2]
            s_next.flags[sdsc_pkg::ST_STOP_AT_GAP_REQUEST]   = 1'b0; // [R2]
            s_next.irq_st[sdsc_pkg::IQ_TC]  = 1'b0; // [R2]
            s_next.irq_st[sdsc_pkg::IQ_BRR] = 1'b0; // [R3]
            s_next.irq_st[sdsc_pkg::IQ_BWR] = 1'b0;
            s_next.irq_st[sdsc_pkg::IQ_BGE] = 1'b0;
        end
        if (s_reg.crst) begin
            s_next.flags[sdsc_pkg::ST_COMMAND_INHIBIT] = 1'b0; // [R4]
            s_next.irq_st[sdsc_pkg::IQ_CC]  = 1'b0; // [R5]
        end
        if (s_reg.arst) begin
            s_next.flags  = '0; // [R6]
            s_next.irq_st = '0;
            s_next.irq_en = '0;
            s_next.internal_clock_enable    = 1'b0;
            s_next.card_clock_enable    = 1'b0;
            s_next.div    = '0;
            s_next.tsel   = '0;
        end
        s_next.irq = |(s_next.irq_st & s_next.irq_en);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else if (ce_i) begin
            s_reg <= s_next;
        end
    end

    assign wb_ack_o   = s_reg.ack;
    assign wb_dat_o   = s_reg.dat;
    assign irq_o      = s_reg.irq;
    assign card_clk_o = cclk;
    assign data_rst_o = s_reg.drst_pin; // [R3]
    assign cmd_rst_o  = s_reg.crst_pin;
    assign all_rst_o  = s_reg.arst;

    property p_srd_self_clear;
        @(posedge clk_i) disable iff (rst_i)
            ($rose(s_reg.drst) && ce_i) ##1 ce_i[*4] |-> !s_reg.drst;
    endproperty
    a_srd_self_clear: assert property (p_srd_self_clear) else $error("data reset stuck"); // [R1]

    property p_srd_flags;
        @(posedge clk_i) disable iff (rst_i)
            (s_reg.drst && ce_i) |=> (s_reg.flags[5:0] == 6'h00 && !s_reg.flags[7]);
    endproperty
    a_srd_flags: assert property (p_srd_flags) else $error("data flags survived reset"); // [R2]

    property p_src_cc;
        @(posedge clk_i) disable iff (rst_i)
            (s_reg.crst && ce_i && !ev_all[3]) |=> !s_reg.irq_st[3];
    endproperty
    a_src_cc: assert property (p_src_cc) else $error("command done survived reset"); // [R5]

    property p_readback;
        @(posedge clk_i) disable iff (rst_i)
            (ce_i && wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
             && wb_adr_i == sdsc_pkg::SYSCTL_OFF && s_reg.srd_st != sdsc_pkg::SDSC_RST_IDLE)
            |=> wb_dat_o[sdsc_pkg::SRD_BIT];
    endproperty
    a_readback: assert property (p_readback) else $error("reset bit read zero while busy"); // [R17]

    property p_sra_done;
        @(posedge clk_i) disable iff (rst_i)
            $rose(s_reg.arst) |-> ##[1:20] !s_reg.arst;
    endproperty
    a_sra_done: assert property (p_sra_done) else $error("global reset never ends"); // [R6]

    property p_irq;
        @(posedge clk_i) disable iff (rst_i)
            irq_o == |(s_reg.irq_st & s_reg.irq_en);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt mismatch");
endmodule // sdsc_sysctl
`default_nettype wire

// ===== verif/sdsc_card_model.sv
// sdsc_card_model: card side that waits for data, busy end or crc token.
// assumes the host clock; a prompt card answers within 8 cycles.
`timescale 1ns/1ps
`default_nettype none
module sdsc_card_model (
    input  wire logic       clk_i,  // system clock
    input  wire logic [2:0] req_i,  // data, busy, crc wait asked
    input  wire logic       slow_i, // card stays silent
    output logic [2:0]      wait_o  // waits as seen by host
);
    int edges = 0;
    // a silent card holds the wait until the host gives up
    always_ff @(posedge clk_i) begin
        if (req_i == 3'h0)
            edges <= 0;
        else
            edges <= edges + 1;
    end
    assign wait_o = (slow_i || edges < 8) ? req_i : 3'h0;
endmodule // sdsc_card_model
`default_nettype wire

// ===== verif/tb_sdsc_sysctl.sv
// tb_sdsc_sysctl: self-checking bench of the system control block.
// assumes the package, design and card model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_sdsc_sysctl;
    logic        clk_i = 0, rst_i = 1, cyc = 0, we = 0, tick = 0, slow = 0;
    logic [7:0]  adr = 8'h00, ev = 8'h00;
    logic [6:0]  fset = 7'h00;
    logic [31:0] wdat = 32'h0, q, rdat;
    logic [2:0]  req = 3'h0, waits, seen = 3'h0;
    logic        ack, irq, cclk, prevc, drst, crst, arst;
    logic [31:0] keep_st [3] = '{32'h40, 32'hbf, 32'h0};
    logic [31:0] keep_iq [3] = '{32'h08, 32'hf0, 32'h0};
    int          fails = 0, check_count = 0, n, k, div;
    always #5 clk_i = ~clk_i;
    // watch reset pulses and card clock edges
    always @(posedge clk_i) begin
        if (!rst_i) seen <= seen | {arst, crst, drst};
        prevc <= cclk;
    end
    sdsc_sysctl sdsc_sysctl_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat),
        .tick_i(tick), .gate_i(1'b0), .data_wait_i(waits[0]),
        .busy_wait_i(waits[1]), .crc_wait_i(waits[2]), .ev_i(ev),
        .flag_set_i(fset), .flag_clr_i(7'h00), .irq_o(irq), .card_clk_o(cclk),
        .data_rst_o(drst), .cmd_rst_o(crst), .all_rst_o(arst));
    sdsc_card_model sdsc_card_model_inst (.clk_i(clk_i), .req_i(req),
        .slow_i(slow), .wait_o(waits));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // one classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            t++;
        end while (ack !== 1'b1 && t < 50);
        q = rdat;
        if (t >= 50) begin
            fails++;
            print_verdict();
        end
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask
    initial begin
        void'($urandom(81007));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(0, sdsc_pkg::SYSCTL_OFF, 0);
        chk(q, sdsc_pkg::SYSCTL_RESET);
        wb(1, 8'h40, 32'hffff_ffff);
        wb(0, 8'h40, 0);
        chk(q, 32'h0);
        $display("reset values done");
        // data, command, then global reset, flags raised before each
        for (k = 0; k < 3; k++) begin
            fset <= 7'h7f;
            ev <= 8'hf8;
            @(posedge clk_i);
            fset <= 7'h00;
            ev <= 8'h00;
            wb(1, sdsc_pkg::SYSCTL_OFF, 32'h1 << (26 - k));
            wb(0, sdsc_pkg::SYSCTL_OFF, 0);
            chk(q[26-k], 1'b1);
            n = 0;
            do begin
                wb(0, sdsc_pkg::SYSCTL_OFF, 0);
                n++;
            end while (q[26-k] !== 1'b0 && n < 20);
            chk(q[26:24], 3'h0);
            wb(0, sdsc_pkg::STATUS_OFF, 0);
            chk(q, keep_st[k]);
            wb(0, sdsc_pkg::IRQST_OFF, 0);
            chk(q, keep_iq[k]);
        end
        chk(seen, 3'h7);
        $display("soft resets done");
        // divider: stable flag first, then card clock period
        div = 2 + $urandom % 6;
        wb(1, sdsc_pkg::SYSCTL_OFF, (div << 6) | 1);
        n = 0;
        do begin
            wb(0, sdsc_pkg::SYSCTL_OFF, 0);
            n++;
        end while (q[1] !== 1'b1 && n < 20);
        chk(q, (div << 6) | 3);
        wb(1, sdsc_pkg::SYSCTL_OFF, (div << 6) | 5);
        for (k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(negedge clk_i);
                n++;
            end while (!(cclk === 1'b1 && prevc === 1'b0) && n < 100);
        end
        chk(n, div);
        wb(1, sdsc_pkg::SYSCTL_OFF, ((div + 1) << 6) | 1);
        wb(0, sdsc_pkg::SYSCTL_OFF, 0);
        chk(q[1], 1'b0);
        repeat (4) @(posedge clk_i);
        n = 0;
        repeat (20) begin
            @(negedge clk_i);
            n += (cclk !== 1'b0);
        end
        chk(n, 0);
        $display("clock control done");
        // silent card: data, busy, crc waits with codes 0 to 2
        wb(1, sdsc_pkg::IRQEN_OFF, 32'h7);
        tick <= 1'b1;
        slow <= 1'b1;
        for (k = 0; k < 3; k++) begin
            wb(1, sdsc_pkg::SYSCTL_OFF, k << 16);
            req <= 3'h1 << k;
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
            end while (irq !== 1'b1 && n < 40000);
            chk(n >= (1 << (13 + k)) && n < (1 << (13 + k)) + 8, 1'b1);
            wb(0, sdsc_pkg::IRQST_OFF, 0);
            chk(q, 32'h1 << k);
            req <= 3'h0;
            wb(1, sdsc_pkg::IRQEN_OFF, 0);
            @(negedge clk_i);
            chk(irq, 1'b0);
            wb(1, sdsc_pkg::IRQST_OFF, 32'h1 << k);
            wb(1, sdsc_pkg::IRQEN_OFF, 32'h7);
            wb(0, sdsc_pkg::IRQST_OFF, 0);
            chk(q, 32'h0);
        end
        // prompt card, many short waits: only their sum passes 2^13 ticks
        wb(1, sdsc_pkg::SYSCTL_OFF, 0);
        slow <= 1'b0;
        repeat (1100) begin
            req <= 3'h7;
            repeat (10) @(posedge clk_i);
            req <= 3'h0;
            @(posedge clk_i);
        end
        wb(0, sdsc_pkg::IRQST_OFF, 0);
        chk(q, 32'h0);
        $display("time-outs done");
        print_verdict();
    end
endmodule // tb_sdsc_sysctl
`default_nettype wire
